/* core/top_irq_pkg.sv */
// Package: register map, field layout and counts of the top interrupt and watchdog block
package top_irq_pkg;
  // ==========================================================
  // Register offsets (demultiplexed addressing)
  localparam logic [7:0] WATCHDOG_CONTROL_OFS = 8'h40;
  localparam logic [7:0] TOP_INTERRUPT_STATUS_OFS = 8'h41;
  localparam logic [7:0] TOP_INTERRUPT_MASK_OFS = 8'h41;
  // ==========================================================
  // Reset values
  localparam logic [7:0] WATCHDOG_CONTROL_RST = 8'h1f;
  localparam logic [7:0] TOP_INTERRUPT_STATUS_RST = 8'h00;
  localparam logic [7:0] TOP_INTERRUPT_MASK_RST = 8'h00;
  // ==========================================================
  // Status and mask field positions
  localparam int WD_BIT = 7;
  localparam int ARB_BIT = 6;
  localparam int SWU_BIT = 5;
  localparam int HBX_BIT = 4;
  localparam int HB_BIT = 3;
  localparam int HAX_BIT = 2;
  localparam int HA_BIT = 1;
  // Watchdog control fields
  localparam int SVC_FIRST_BIT = 7;
  localparam int SVC_SECOND_BIT = 6;
  localparam int START_BIT = 5;
  localparam logic [7:0] WDC_FIXED_ONES = 8'h1f;
  // ==========================================================
  // Timing counts
  localparam int WD_PERIOD_FRAMES = 1024;
  localparam int SERVICE_GAP_CLOCKS = 2;
  localparam int MASK_GAP_CYCLES = 1;
  localparam int RESET_PULSE_CYCLES = 4;

  // Sub-unit interrupt requests travel together
  typedef struct packed {
    logic switchUnit;
    logic hdlcBExt;
    logic hdlcB;
    logic hdlcAExt;
    logic hdlcA;
  } subunit_irq_type;

  // Service sequence position
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_ARMED = 3'b010,
    WD_HALF = 3'b100
  } wd_state_type;
endpackage

/* core/top_interrupt_and_watchdog.sv */
// Top-level interrupt summary, mask and software watchdog
// Function
// - Status bit7 watchdog, bits6..1 arbiter..hdlc A, bit0 reads zero.
// - Watchdog expiry pulses reset output and sets watchdog flag.
// - Arbiter suspend timeout while awaiting frame sets arbiter flag.
// - Status read clears watchdog and arbiter; others clear at sub-unit reads.
// - Mask bit per flag position, one disables, reset all enabled.
// - Masked arbiter event hidden, held, shown after unmasking.
// - Watchdog unmaskable; mask bit7 writes zero; reads at mask offset return status.
// - Masked sub-unit flags still read but do not drive interrupt.
// - Mask write while interrupt pending briefly drops interrupt output.
// - Start bit starts watchdog; only resets stop it.
// - Only correctly ordered service pair or an expiry restarts watchdog period.
`timescale 1ns/1ps
`default_nettype none
module top_interrupt_and_watchdog
  import top_irq_pkg::*;
(
  // Clock and reset (clock is the PCM clock domain)
  input wire logic clk_sys,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // Events
  input wire logic frameSync,
  input wire logic arbiterTimeout,
  input wire subunit_irq_type subunitIrq,
  // Outputs
  output logic interruptOut,
  output logic resetOutputPin
);
  // ==========================================================
  // Address decode
  wire wdcSel = (regAddr == WATCHDOG_CONTROL_OFS);
  wire topSel = (regAddr == TOP_INTERRUPT_STATUS_OFS);
  wire wdcWr = regWr & wdcSel;
  wire maskWr = regWr & (regAddr == TOP_INTERRUPT_MASK_OFS);
  wire statusRd = regRd & topSel;

  logic wdFlag_r;
  logic arbPend_r;
  logic [7:0] mask_r;
  logic wdRun_r;
  logic [1:0] svc_r;
  wd_state_type wdState_r;
  wd_state_type wdState_nxt;
  logic [9:0] frameCnt_r;
  logic [2:0] rstCnt_r;
  logic gap_r;
  logic [7:0] regRdata_r;

  // ==========================================================
  // Watchdog service sequence: first 1/0, then 0/1
  wire svcFirst = wdcWr & regWdata[SVC_FIRST_BIT] & ~regWdata[SVC_SECOND_BIT];
  wire svcSecond = wdcWr & ~regWdata[SVC_FIRST_BIT] & regWdata[SVC_SECOND_BIT];
  wire svcDone = (wdState_r == WD_HALF) & svcSecond;
  wire wdExpire = wdRun_r & frameSync & (frameCnt_r == 10'(WD_PERIOD_FRAMES - 1)) & ~svcDone;

  // Next sequence position; a wrong-order write drops back to armed
  always_comb begin
    wdState_nxt = wdState_r;
    unique case (wdState_r)
      WD_IDLE: if (wdcWr & regWdata[START_BIT]) wdState_nxt = WD_ARMED;
      WD_ARMED: if (svcFirst) wdState_nxt = WD_HALF;
      WD_HALF: if (svcDone | (wdcWr & ~svcFirst)) wdState_nxt = WD_ARMED;
      default: wdState_nxt = WD_IDLE;
    endcase
  end

  // Watchdog state and frame counter; only rst_b stops it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdState_r <= WD_IDLE;
      wdRun_r <= 1'b0;
      frameCnt_r <= 10'h000;
    end else begin
      wdState_r <= wdState_nxt;
      if (wdcWr & regWdata[START_BIT]) wdRun_r <= 1'b1;
      if (svcDone | wdExpire) frameCnt_r <= 10'h000;
      else if (wdRun_r & frameSync) frameCnt_r <= frameCnt_r + 10'h001;
    end
  end

  // Readback copy of service bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b) svc_r <= 2'b00;
    else if (wdcWr) svc_r <= {regWdata[SVC_FIRST_BIT], regWdata[SVC_SECOND_BIT]};
  end

  // Reset output pulse stretcher
  always_ff @(posedge clk_sys) begin
    if (!rst_b) rstCnt_r <= 3'h0;
    else if (wdExpire) rstCnt_r <= 3'(RESET_PULSE_CYCLES);
    else if (rstCnt_r != 3'h0) rstCnt_r <= rstCnt_r - 3'h1;
  end
  assign resetOutputPin = (rstCnt_r != 3'h0);

  // ==========================================================
  // Sticky flags: set wins over a clearing status read
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wdFlag_r <= 1'b0;
      arbPend_r <= 1'b0;
    end else begin
      if (wdExpire) wdFlag_r <= 1'b1;
      else if (statusRd) wdFlag_r <= 1'b0;
      if (arbiterTimeout) arbPend_r <= 1'b1;
      else if (statusRd & ~mask_r[ARB_BIT]) arbPend_r <= 1'b0;
    end
  end

  // Mask register; bits 7 and 0 have no storage
  always_ff @(posedge clk_sys) begin
    if (!rst_b) mask_r <= TOP_INTERRUPT_MASK_RST;
    else if (maskWr) mask_r <= regWdata & 8'h7e;
  end

  // Status view; sub-unit flags are live and clear at their own registers
  wire [7:0] statusView = {wdFlag_r, arbPend_r & ~mask_r[ARB_BIT], subunitIrq, 1'b0};
  wire [7:0] enabledView = {wdFlag_r, arbPend_r, subunitIrq, 1'b0} & ~mask_r;
  wire anyPend = |enabledView;

  // Drop interrupt in the mask write cycle and the one after so an edge reappears
  always_ff @(posedge clk_sys) begin
    if (!rst_b) gap_r <= 1'b0;
    else gap_r <= maskWr & anyPend;
  end
  assign interruptOut = anyPend & ~gap_r & ~(maskWr & anyPend);

  // Read data register
  wire [7:0] wdcView = {svc_r, wdRun_r, WDC_FIXED_ONES[4:0]};
  always_ff @(posedge clk_sys) begin
    if (!rst_b) regRdata_r <= 8'h00;
    else if (regRd) regRdata_r <= wdcSel ? wdcView : (topSel ? statusView : 8'h00);
  end
  assign regRdata = regRdata_r;

  // ==========================================================
  // Checks
  property p_wd_flag;
    @(posedge clk_sys) disable iff (!rst_b) wdExpire |=> wdFlag_r && resetOutputPin;
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("watchdog expiry lost");
  property p_bit0;
    @(posedge clk_sys) disable iff (!rst_b) regRd && topSel |=> regRdata[0] == 1'b0;
  endproperty
  a_bit0: assert property (p_bit0) else $error("status bit0 not zero");
  property p_clear;
    @(posedge clk_sys) disable iff (!rst_b) statusRd && !wdExpire |=> !wdFlag_r;
  endproperty
  a_clear: assert property (p_clear) else $error("watchdog flag not cleared");
  property p_arb_set;
    @(posedge clk_sys) disable iff (!rst_b) arbiterTimeout |=> arbPend_r;
  endproperty
  a_arb_set: assert property (p_arb_set) else $error("arbiter event lost");
  property p_mask7;
    @(posedge clk_sys) disable iff (!rst_b) maskWr |=> !mask_r[7] && !mask_r[0];
  endproperty
  a_mask7: assert property (p_mask7) else $error("mask bit7 stored");
  property p_masked_arb;
    @(posedge clk_sys) disable iff (!rst_b) mask_r[ARB_BIT] && statusRd |=> arbPend_r == $past(arbPend_r) || arbPend_r;
  endproperty
  a_masked_arb: assert property (p_masked_arb) else $error("masked arbiter lost");
  property p_gap;
    @(posedge clk_sys) disable iff (!rst_b) maskWr && anyPend |-> !interruptOut ##1 !interruptOut;
  endproperty
  a_gap: assert property (p_gap) else $error("no mask write gap");
  property p_level;
    @(posedge clk_sys) disable iff (!rst_b) !anyPend |-> !interruptOut;
  endproperty
  a_level: assert property (p_level) else $error("interrupt without source");
  property p_run;
    @(posedge clk_sys) disable iff (!rst_b) wdRun_r |=> wdRun_r;
  endproperty
  a_run: assert property (p_run) else $error("watchdog stopped");
  property p_svc;
    @(posedge clk_sys) disable iff (!rst_b) svcDone |=> frameCnt_r == 10'h000;
  endproperty
  a_svc: assert property (p_svc) else $error("service not counted");
  // ==========================================================
  // Checks on reset state, masking and service order
  // Reset must leave every source enabled and the watchdog stopped
  property p_mask_reset;
    @(posedge clk_sys) $rose(rst_b) |-> mask_r == TOP_INTERRUPT_MASK_RST && !wdRun_r;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("reset left a source masked");
  property p_arb_clear;
    @(posedge clk_sys) disable iff (!rst_b) statusRd && !mask_r[ARB_BIT] && !arbiterTimeout |=> !arbPend_r;
  endproperty
  a_arb_clear: assert property (p_arb_clear) else $error("arbiter flag survived a read");
  property p_arb_hidden;
    @(posedge clk_sys) disable iff (!rst_b) statusRd && mask_r[ARB_BIT] |=> !regRdata[ARB_BIT];
  endproperty
  a_arb_hidden: assert property (p_arb_hidden) else $error("masked arbiter flag shown");
  // Masked sub-unit levels alone must never raise the line
  property p_sub_masked;
    @(posedge clk_sys) disable iff (!rst_b)
      (subunitIrq & ~mask_r[SWU_BIT:HA_BIT]) == 5'h00 && !wdFlag_r && (!arbPend_r || mask_r[ARB_BIT])
      |-> !interruptOut;
  endproperty
  a_sub_masked: assert property (p_sub_masked) else $error("masked source drove interrupt");
  property p_wd_unmasked;
    @(posedge clk_sys) disable iff (!rst_b) wdFlag_r && !maskWr && !gap_r |-> interruptOut;
  endproperty
  a_wd_unmasked: assert property (p_wd_unmasked) else $error("watchdog interrupt masked");
  // Pulse length is fixed so the far side sees one clean reset
  property p_rst_pulse;
    @(posedge clk_sys) disable iff (!rst_b) wdExpire |=> resetOutputPin [*4] ##1 !resetOutputPin;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset output pulse width");
  property p_wrong_order;
    @(posedge clk_sys) disable iff (!rst_b) wdState_r == WD_ARMED && svcSecond |=> wdState_r == WD_ARMED;
  endproperty
  a_wrong_order: assert property (p_wrong_order) else $error("second service write taken first");
  // Without a half-done pair the last frame of the period must expire
  property p_unserved;
    @(posedge clk_sys) disable iff (!rst_b)
      wdRun_r && wdState_r != WD_HALF && frameSync && frameCnt_r == 10'(WD_PERIOD_FRAMES - 1) |=> wdFlag_r;
  endproperty
  a_unserved: assert property (p_unserved) else $error("unserved watchdog did not expire");
  c_expire: cover property (@(posedge clk_sys) disable iff (!rst_b) wdExpire);
  c_service: cover property (@(posedge clk_sys) disable iff (!rst_b) svcDone);
  c_gap: cover property (@(posedge clk_sys) disable iff (!rst_b) maskWr && anyPend);
  c_masked_hold: cover property (@(posedge clk_sys) disable iff (!rst_b) mask_r[ARB_BIT] && arbPend_r);
  c_wrong_order: cover property (@(posedge clk_sys) disable iff (!rst_b) wdState_r == WD_ARMED && svcSecond);
endmodule // top_interrupt_and_watchdog
`default_nettype wire

/* tb/wd_host_model.sv */
// Host processor model on the register port of the interrupt and watchdog block
`timescale 1ns/1ps
`default_nettype none
module wd_host_model
  import top_irq_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [7:0] regAddr,
  output logic regWr,
  output logic regRd,
  output logic [7:0] regWdata
);
  // Idle bus at time zero
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end
  // ==========================================================
  // One access; released lines show the inverse so stale values never pass
  task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = d;
    regWr = wr;
    regRd = !wr;
    @(negedge clk_sys);
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = ~a;
    regWdata = ~d;
    @(negedge clk_sys);
  endtask
  // Service pair in the only accepted order, three clocks apart
  task automatic service();
    access(WATCHDOG_CONTROL_OFS, 8'h80, 1'b1);
    access(WATCHDOG_CONTROL_OFS, 8'h40, 1'b1);
  endtask
endmodule // wd_host_model
`default_nettype wire

/* tb/top_interrupt_and_watchdog_bench.sv */
// Self-checking bench for the top interrupt and watchdog block
`timescale 1ns/1ps
`default_nettype none
module top_interrupt_and_watchdog_bench
  import top_irq_pkg::*;
;
  logic clk_sys, rst_b, regWr, regRd, frameSync, arbiterTimeout, interruptOut, resetOutputPin;
  logic [7:0] regAddr, regWdata, regRdata;
  logic [7:0] expQ[$];
  logic [4:0] v;
  subunit_irq_type subunitIrq;
  int failCount = 0;
  int totalChecks = 0;
  int resetHigh = 0;
  top_interrupt_and_watchdog DUT (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata), .frameSync(frameSync),
    .arbiterTimeout(arbiterTimeout), .subunitIrq(subunitIrq), .interruptOut(interruptOut),
    .resetOutputPin(resetOutputPin));
  wd_host_model host (.clk_sys(clk_sys), .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regWdata(regWdata));
  // ==========================================================
  // Clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Reads queue their expectation; the monitor below judges the answer
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    expQ.push_back(exp);
    host.access(a, 8'h00, 1'b0);
  endtask
  task automatic irq(input logic exp);
    @(negedge clk_sys);
    check("interruptOut", {7'h00, interruptOut}, {7'h00, exp});
  endtask
  // Frames four clocks long, so 1024 of them stay well inside the run
  task automatic frames(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      frameSync = 1'b1;
      @(negedge clk_sys);
      frameSync = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
  endtask
  // Read monitor: data is judged a cycle and a half after the taking edge
  always begin
    @(posedge clk_sys);
    if (regRd === 1'b1) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("regRdata", regRdata, expQ.pop_front());
    end
  end
  // Width of the reset output pulse, in clocks; sampled mid-cycle where it has settled
  always @(negedge clk_sys) if (resetOutputPin === 1'b1) resetHigh++;
  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    frameSync = 1'b0;
    arbiterTimeout = 1'b0;
    subunitIrq = '0;
    void'($urandom(32'h3c72d983));
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    rd(8'h41, 8'h00);
    rd(8'h40, WATCHDOG_CONTROL_RST);
    rd(8'h42, 8'h00);
    v = 5'($urandom()) | 5'h01;
    subunitIrq = v;
    irq(1'b1);
    rd(8'h41, {2'b00, v, 1'b0});
    fork
      host.access(8'h41, 8'h00, 1'b1);
      begin
        @(posedge clk_sys iff regWr === 1'b1);
        #1 check("maskDrop", {7'h00, interruptOut}, 8'h00);
      end
    join
    irq(1'b1);
    host.access(8'h41, 8'hff, 1'b1);
    irq(1'b0);
    rd(8'h41, {2'b00, v, 1'b0});
    subunitIrq = '0;
    // Masked arbiter event is held and shown after unmasking
    host.access(8'h41, 8'h40, 1'b1);
    @(negedge clk_sys) arbiterTimeout = 1'b1;
    @(negedge clk_sys) arbiterTimeout = 1'b0;
    irq(1'b0);
    rd(8'h41, 8'h00);
    host.access(8'h41, 8'h00, 1'b1);
    irq(1'b1);
    rd(8'h41, 8'h40);
    rd(8'h41, 8'h00);
    irq(1'b0);
    // Watchdog: served twice, then stop attempt and a pair in the wrong order
    host.access(8'h40, 8'h20, 1'b1);
    rd(8'h40, 8'h3f);
    frames(600);
    host.service();
    frames(600);
    host.service();
    frames(300);
    check("resetHigh", 8'(resetHigh), 8'h00);
    host.access(8'h40, 8'h00, 1'b1);
    host.access(8'h40, 8'h40, 1'b1);
    host.access(8'h40, 8'h80, 1'b1);
    host.access(8'h41, 8'hff, 1'b1);
    frames(800);
    check("resetHigh", 8'(resetHigh), 8'(RESET_PULSE_CYCLES));
    irq(1'b1);
    rd(8'h41, 8'h80);
    rd(8'h41, 8'h00);
    irq(1'b0);
    printVerdict();
  end
  // Hang guard, well beyond the 9,300 clocks the sequence needs
  initial begin
    #(20 * 30000);
    failCount++;
    printVerdict();
  end
endmodule // top_interrupt_and_watchdog_bench
`default_nettype wire
